// ---- design/dpars_pkg.sv ----
// Constants and carrier types for the phase-aligned receive channel
package dpars_pkg;
  localparam int        PHASE_COUNT   = 8;
  localparam int        PHASE_BITS    = 3;
  localparam int        PHASE_HALF    = 4;
  localparam int        PERIOD_BITS   = 9;
  localparam int        FIFO_DEPTH    = 4;
  localparam int        FIFO_PTR_BITS = 2;
  localparam int        FIFO_READ_LAG = 2;
  localparam int        LOCK_COUNT    = 16;
  localparam int        LOCK_BITS     = 5;
  localparam int        TRAIN_REPEAT  = 256;
  localparam int        FACTOR_DEF    = 8;
  localparam int        FACTOR_ALT    = 10;
  localparam logic      RESET_BIT     = 1'b0;

  typedef struct packed {
    logic                  locked;
    logic [PHASE_BITS-1:0] phase;
  } dpars_status_s;
endpackage

// ---- design/dpars_fifo_mem.sv ----
// Four-entry word store with registered read data
`timescale 1ns/1ps
`default_nettype none
module dpars_fifo_mem
  import dpars_pkg::*;
#(
  parameter int WIDTH = FACTOR_DEF
)(
  // Clock
  input  wire logic                     core_clk_in,
  // Write side
  input  wire logic                     wr_strobe_in,
  input  wire logic [FIFO_PTR_BITS-1:0] wr_addr_in,
  input  wire logic [WIDTH-1:0]         wr_data_in,
  // Read side
  input  wire logic [FIFO_PTR_BITS-1:0] rd_addr_in,
  output logic      [WIDTH-1:0]         rd_data_out
);
  logic [WIDTH-1:0] mem [FIFO_DEPTH];

  // No reset on storage; the first reads at addresses 0 and 1 after reset return unwritten words, the pointer lag covers the rest
  always_ff @(posedge core_clk_in)
  begin
    if (wr_strobe_in)
    begin
      mem[wr_addr_in] <= wr_data_in;
    end
    rd_data_out <= mem[rd_addr_in];
  end
endmodule
`default_nettype wire

// ---- design/dpars_channel.sv ----
// Receive channel: phase selection, deserializer, synchronizer, realigner
`timescale 1ns/1ps
`default_nettype none
module dpars_channel
  import dpars_pkg::*;
#(
  parameter int J = FACTOR_DEF
)(
  // Clock and reset
  input  wire logic          core_clk_in,
  input  wire logic          reset_n_in,
  // Link pins
  input  wire logic          link_clk_in,
  input  wire logic          link_data_in,
  // Fabric side
  input  wire logic          shared_fabric_clock_in,
  input  wire logic          realign_req_in,
  output logic [J-1:0]       word_data_out,
  output logic               word_valid_out,
  output var dpars_status_s  status_out
);
  // Refuse any factor other than the two the package defines, 8 and 10
  if (J != FACTOR_DEF && J != FACTOR_ALT)
  begin : g_bad_factor
    $error("Deserialization factor must be 8 or 10");
  end

  function automatic logic [J-1:0] slip_window(input logic [J-1:0] later,
                                                input logic [J-1:0] earlier,
                                                input logic [3:0]   k);
    logic [2*J-1:0] both;
    both = {later, earlier} << k;
    return both[2*J-1 -: J];
  endfunction

  // Two-stage synchronisers for every pin, third stage for edge finding
  logic [2:0] lclk_sync;
  logic [2:0] data_sync;
  logic [2:0] fclk_sync;
  logic [2:0] req_sync;

  always_ff @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      lclk_sync <= '0;
      data_sync <= '0;
      fclk_sync <= '0;
      req_sync  <= '0;
    end
    else
    begin
      lclk_sync <= {lclk_sync[1:0], link_clk_in};
      data_sync <= {data_sync[1:0], link_data_in};
      fclk_sync <= {fclk_sync[1:0], shared_fabric_clock_in};
      req_sync  <= {req_sync[1:0], realign_req_in};
    end
  end

  wire link_edge  = lclk_sync[1] & ~lclk_sync[2];
  wire data_trans = data_sync[1] ^ data_sync[2];
  wire data_bit   = data_sync[1];
  wire fab_tick   = fclk_sync[1] & ~fclk_sync[2];
  wire req_level  = req_sync[1];

  // Bit period measured in core cycles, split into eight bins
  logic [PERIOD_BITS-1:0] period_cnt;
  logic [PERIOD_BITS-1:0] period;
  logic [PERIOD_BITS-1:0] acc;
  logic [PHASE_BITS-1:0]  bin;
  logic [PHASE_BITS-1:0]  sel;
  logic                   locked;
  logic [LOCK_BITS-1:0]   lock_cnt;

  wire [PERIOD_BITS-1:0] acc_step  = acc + PERIOD_BITS'(PHASE_COUNT);
  wire                   bin_cross = (acc_step >= period) && (bin != PHASE_BITS'(PHASE_COUNT-1));
  wire [PHASE_BITS-1:0]  next_bin  = link_edge ? '0 : (bin_cross ? bin + 1'b1 : bin);
  wire [PERIOD_BITS-1:0] next_acc  = link_edge ? '0 : (bin_cross ? acc_step - period : acc_step);
  wire                   sample_now = (next_bin == sel) && (next_bin != bin || link_edge);

  // Best sample point sits half a bit away from where data toggles
  wire [PHASE_BITS-1:0]  target    = bin + PHASE_BITS'(PHASE_HALF);
  wire [PHASE_BITS-1:0]  phase_err = target - sel;
  wire                   near_lock = (phase_err == 3'h0) || (phase_err == 3'h1) ||
                                     (phase_err == 3'h7);
  wire [PHASE_BITS-1:0]  next_sel  = !data_trans ? sel :
                                     (phase_err == 3'h0) ? sel :
                                     (phase_err < 3'h4) ? sel + 1'b1 : sel - 1'b1;

  always_ff @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      period_cnt <= '0;
      period     <= '1;
      acc        <= '0;
      bin        <= '0;
      sel        <= '0;
      locked     <= 1'b0;
      lock_cnt   <= '0;
    end
    else
    begin
      period_cnt <= link_edge ? PERIOD_BITS'(1) : period_cnt + 1'b1;
      if (link_edge && period_cnt != '0)
        period <= period_cnt;
      acc <= next_acc;
      bin <= next_bin;
      sel <= next_sel;
      // Lock is declared after enough steady transitions of any pattern
      if (data_trans && !locked)
        lock_cnt <= near_lock ? lock_cnt + 1'b1 : '0;
      if (lock_cnt == LOCK_BITS'(LOCK_COUNT))
        locked <= 1'b1;
    end
  end

  // Deserializer; word boundary is arbitrary until slipped
  logic [J-1:0] shift;
  logic [3:0]   bit_cnt;
  logic         word_strobe;
  logic [J-1:0] word_cap;
  logic [FIFO_PTR_BITS-1:0] wr_ptr;
  logic [FIFO_PTR_BITS-1:0] rd_ptr;

  wire [J-1:0] next_shift = {shift[J-2:0], data_bit};
  wire         word_done  = sample_now && (bit_cnt == 4'(J-1));

  always_ff @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      shift       <= '0;
      bit_cnt     <= '0;
      word_strobe <= 1'b0;
      word_cap    <= '0;
      wr_ptr      <= FIFO_PTR_BITS'(FIFO_READ_LAG);
      rd_ptr      <= '0;
    end
    else
    begin
      word_strobe <= word_done;
      if (sample_now)
      begin
        shift   <= next_shift;
        bit_cnt <= word_done ? '0 : bit_cnt + 1'b1;
      end
      if (word_done)
        word_cap <= next_shift;
      // Pointers run free with no flags; frequency lock keeps the lag
      if (word_strobe)
        wr_ptr <= wr_ptr + 1'b1;
      if (fab_tick)
        rd_ptr <= rd_ptr + 1'b1;
    end
  end

  logic [J-1:0] fifo_word;

  dpars_fifo_mem #(
    .WIDTH (J)
  ) u_mem (
    .core_clk_in  (core_clk_in),
    .wr_strobe_in (word_strobe),
    .wr_addr_in   (wr_ptr),
    .wr_data_in   (word_cap),
    .rd_addr_in   (rd_ptr),
    .rd_data_out  (fifo_word)
  );

  // Realigner on shared clock ticks; always in path
  logic [J-1:0] stage2;
  logic [J-1:0] stage3;
  logic [3:0]   slip;
  logic         req_prev;

  wire       req_rise  = req_level && !req_prev;
  wire       slip_wrap = req_rise && (slip == 4'(J-1));
  wire [3:0] next_slip = slip_wrap ? '0 : (req_rise ? slip + 1'b1 : slip);

  always_ff @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      stage2         <= '0;
      stage3         <= '0;
      slip           <= '0;
      req_prev       <= 1'b0;
      word_data_out  <= '0;
      word_valid_out <= 1'b0;
      status_out     <= '0;
    end
    else
    begin
      status_out <= '{locked: locked, phase: sel};
      word_valid_out <= 1'b0;
      if (fab_tick)
      begin
        req_prev       <= req_level;
        stage2         <= fifo_word;
        stage3         <= stage2;
        slip           <= next_slip;
        word_data_out  <= slip_window(stage3, stage2, slip);
        word_valid_out <= !slip_wrap;
      end
    end
  end

  // Phase moves by at most one bin per cycle
  phase_step_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    (sel == $past(sel)) || (sel == $past(sel) + 3'h1) || (sel == $past(sel) - 3'h1))
    else $error("Phase select jumped more than one bin");

  // Phase only moves on a data transition
  phase_cause_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    !data_trans |=> $stable(sel))
    else $error("Phase moved without a transition");

  lock_hold_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    locked |=> locked [*4])
    else $error("Lock was lost");

  slip_range_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    slip < 4'(J))
    else $error("Slip count out of range");

  slip_step_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    (fab_tick && req_rise && slip != 4'(J-1)) |=> (slip == $past(slip) + 4'h1))
    else $error("Request edge did not slip one bit");

  no_slip_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    (fab_tick && !req_rise) |=> $stable(slip) ##1 word_valid_out == 1'b0)
    else $error("Slip changed without a request edge");

  wrap_valid_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    (fab_tick && slip_wrap) |=> (slip == 4'h0) && !word_valid_out)
    else $error("Wrap did not drop the valid word");

  valid_tick_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    word_valid_out |-> $past(fab_tick))
    else $error("Word delivered off the shared clock");

  wrptr_cause_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    !word_strobe |=> $stable(wr_ptr))
    else $error("Write pointer moved without a word");

  zero_slip_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    (fab_tick && slip == 4'h0) |=> word_data_out == $past(stage3))
    else $error("Zero slip did not pass later register");
endmodule
`default_nettype wire

// ---- tb/dpars_tx_model.sv ----
// Behavioural serial sender that forwards its own bit clock
`timescale 1ns/1ps
`default_nettype none
module dpars_tx_model
(
  // Control
  input  wire logic       enable_in,
  input  wire logic [2:0] mode_in,
  input  wire logic [5:0] skew_ns_in,
  // Link
  output logic            link_clk_out,
  output logic            link_data_out
);
  logic [19:0] pat;
  int          len;
  int          idx;

  assign len = (mode_in == 3'h0) ? 20 : 8;

  // Training words, sent first bit from the top; repeated while enabled, fewer than 256 times per run
  always_comb
    case (mode_in)
      3'h0:    pat = 20'h003ff; // Ten low then ten high
      3'h1:    pat = 20'h0000f;
      3'h2:    pat = 20'h00090;
      3'h3:    pat = 20'h000aa;
      default: pat = 20'h00055;
    endcase

  initial
  begin
    link_clk_out  = 1'b0;
    link_data_out = 1'b0;
    idx           = 0;
    forever
    begin
      if (!enable_in)
      begin
        // Clock stands still; data wanders so no stale bit can be trusted
        #40 link_data_out = ~link_data_out;
        idx = 0;
      end
      else
      begin
        link_clk_out = 1'b1;
        // Skew moves the data edge against the clock to test tracking
        link_data_out <= #(skew_ns_in) pat[len-1-idx];
        #40 link_clk_out = 1'b0;
        #40 idx = (idx + 1) % len;
      end
    end
  end
endmodule
`default_nettype wire

// ---- tb/dpars_channel_tb.sv ----
// Self-checking bench for the phase-aligned receive channel
`timescale 1ns/1ps
`default_nettype none
module dpars_channel_tb;
  import dpars_pkg::*;
  localparam int TICK = 128;
  typedef struct packed {
    logic [2:0] mode;
    logic [5:0] skew;
    logic [2:0] phase;
  } dpars_row_s;
  localparam dpars_row_s ROWS [5] = '{'{3'h0, 6'h00, 3'h4}, '{3'h1, 6'h0a, 3'h5},
    '{3'h2, 6'h14, 3'h6}, '{3'h3, 6'h28, 3'h0}, '{3'h4, 6'h00, 3'h4}};
  localparam logic [7:0] PAT8 [5] = '{8'h00, 8'h0f, 8'h90, 8'haa, 8'h55};

  logic          core_clk    = 1'b0;
  logic          reset_n     = 1'b0;
  logic          fab_clk     = 1'b0;
  logic          realign_req = 1'b0;
  logic          tx_en       = 1'b0;
  logic [2:0]    mode        = 3'h0;
  logic [5:0]    skew        = 6'h00;
  logic          lclk;
  logic          ldata;
  logic [7:0]    word;
  logic          valid;
  dpars_status_s status;
  int            errors      = 0;
  int            compares    = 0;
  int            ticks       = 0;
  int            valids      = 0;
  logic          counting    = 1'b0;
  logic [7:0]    word_reg;

  dpars_tx_model tx (.enable_in(tx_en), .mode_in(mode), .skew_ns_in(skew),
    .link_clk_out(lclk), .link_data_out(ldata));
  dpars_channel #(.J(FACTOR_DEF)) dut (.core_clk_in(core_clk), .reset_n_in(reset_n),
    .link_clk_in(lclk), .link_data_in(ldata), .shared_fabric_clock_in(fab_clk),
    .realign_req_in(realign_req), .word_data_out(word), .word_valid_out(valid),
    .status_out(status));

  initial
    forever #2.5 core_clk = ~core_clk;
  initial
    forever #320 fab_clk = ~fab_clk; // One word per tick, locked to the bit clock

  always @(posedge fab_clk) if (counting) ticks++;
  // Registered copy of the delivered word; only the slip test's start word is taken from it
  always @(posedge fab_clk) word_reg <= word;
  always @(posedge core_clk) if (counting && valid === 1'b1) valids++;

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic is_rot(input logic [7:0] w, input logic [7:0] p);
    is_rot = 1'b0;
    for (int s = 0; s < 8; s++)
      if (w === ((p << s) | (p >> (8 - s)))) is_rot = 1'b1;
  endfunction

  task automatic do_reset();
    @(posedge core_clk);
    reset_n <= 1'b0;
    tx_en   <= 1'b0;
    repeat (5) @(posedge core_clk);
    check("reset outs", {3'h0, valid, status}, 8'h00);
    check("reset word", word, 8'h00);
    reset_n <= 1'b1;
    tx_en   <= 1'b1;
  endtask

  task automatic wait_lock();
    int n;
    n = 0;
    while (status.locked !== 1'b1 && n < 20000)
    begin
      @(negedge core_clk);
      n++;
    end
    check("locked", {7'h0, status.locked}, 8'h01);
    if (status.locked !== 1'b1) tally_and_finish();
    repeat (2000) @(negedge core_clk);
  endtask

  // Request comes registered off the core clock, as a pin would deliver it
  task automatic slip_once();
    @(posedge core_clk);
    realign_req <= 1'b1; // High for three slow ticks
    repeat (3 * TICK) @(posedge core_clk);
    realign_req <= 1'b0; // Low for four slow ticks
    repeat (4 * TICK) @(posedge core_clk);
  endtask

  initial
  begin
    logic [2:0] d;
    logic [7:0] w0;
    foreach (ROWS[i])
    begin
      mode <= ROWS[i].mode;
      skew <= ROWS[i].skew;
      do_reset();
      wait_lock();
      d = status.phase - ROWS[i].phase;
      check("phase", {7'h0, d inside {3'h7, 3'h0, 3'h1}}, 8'h01);
      @(negedge fab_clk);
      ticks = 0;
      valids = 0;
      counting = 1'b1;
      repeat (4) @(negedge fab_clk);
      counting = 1'b0;
      check("valid count", 8'(valids), 8'(ticks));
      if (ROWS[i].mode != 3'h0)
        check("word rotation", {7'h0, is_rot(word, PAT8[i])}, 8'h01);
      $display("Pattern row %0d done", i);
    end
    // Skew moves after lock: phase must follow without retraining
    skew <= 6'h14;
    repeat (4000) @(negedge core_clk);
    d = status.phase - 3'h6;
    check("phase track", {7'h0, d inside {3'h7, 3'h0, 3'h1}}, 8'h01);
    $display("Tracking test done");
    // Slip through a full word on a pattern whose rotations all differ
    mode <= 3'h2;
    skew <= 6'h00;
    do_reset();
    wait_lock();
    @(negedge fab_clk);
    w0 = word_reg;
    slip_once();
    @(negedge core_clk);
    check("slip one", word, {w0[6:0], w0[7]});
    @(negedge fab_clk);
    ticks = 0;
    valids = 0;
    counting = 1'b1;
    repeat (7) slip_once(); // Keep slipping until the start word returns
    @(negedge fab_clk);
    counting = 1'b0;
    check("slip wrap", word, w0);
    check("wrap valid", 8'(valids), 8'(ticks - 1));
    $display("Slip test done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
